// File: tb/smbus_power_assertions.sv
// Concurrent checks on the two-wire link and the power-mode outputs.
module smbus_power_assertions #(
	parameter int TIMEOUT_CYCLES = 4000
) (
	// Clocks and reset.
	input  wire logic ref_clk_i,
	input  wire logic link_clk_i,
	input  wire logic sys_rst_i,
	// Link lines and drives.
	input  wire logic host_data_oe,
	input  wire logic dev_clock_oe,
	input  wire logic dev_data_oe,
	input  wire logic serial_clock_pin,
	input  wire logic serial_data_pin,
	// Power-mode outputs.
	input  wire logic run_mode_o,
	input  wire logic meas_powered_o,
	input  wire logic set_done_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] quiet_cnt;
	logic [31:0] next_quiet_cnt;
	logic        prev_scl;
	logic        prev_sda;

	////////////////////////////////////////////////////////////////////////////////
	// Counts quiet link cycles while the slave pulls data, so a stuck engine shows.
	always_comb begin
		next_quiet_cnt = quiet_cnt + 32'h1;
		if (serial_clock_pin != prev_scl || serial_data_pin != prev_sda || !dev_data_oe) begin
			next_quiet_cnt = 32'h0;
		end
	end

	// Registers the quiet count and the last line levels.
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			quiet_cnt <= 32'h0;
			prev_scl  <= 1'b1;
			prev_sda  <= 1'b1;
		end else begin
			quiet_cnt <= next_quiet_cnt;
			prev_scl  <= serial_clock_pin;
			prev_sda  <= serial_data_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link-side behaviour of the slave.
	a_clock_never_held: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		!dev_clock_oe) else $error("slave pulled the clock line");
	a_start_by_host: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		($fell(serial_data_pin) && serial_clock_pin) |-> host_data_oe)
		else $error("start condition not made by the host");
	a_data_moves_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		$changed(dev_data_oe) |-> !serial_clock_pin)
		else $error("slave data drive changed while clock high");
	a_timeout_release: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
		dev_data_oe |-> int'(quiet_cnt) <= TIMEOUT_CYCLES + 16)
		else $error("slave kept data low past the idle limit");

	////////////////////////////////////////////////////////////////////////////////
	// Power-mode sequencing on the reference clock.
	a_standby_at_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> (!run_mode_o && !meas_powered_o) [*8])
		else $error("measurement active right after reset");
	a_set_pulse_single: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		set_done_o |=> !set_done_o [*8]) else $error("set done pulse repeated");
	a_set_bounded: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		$rose(meas_powered_o) |-> ##[1:80] set_done_o)
		else $error("conversion set did not finish in time");
	a_wait_after_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		set_done_o |-> !meas_powered_o) else $error("no low-power wait after set");
	a_run_repeats: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(set_done_o && run_mode_o) |-> ##[100:300] (set_done_o || !run_mode_o))
		else $error("run mode stopped converting");
endmodule // smbus_power_assertions

// File: tb/smbus_slave_power_mode_ctrl_bench.sv
// Bench joining host and sensor over the link, with random and corner-case traffic.
`include "smbus_power_map.svh"

module smbus_slave_power_mode_ctrl_bench
	import smbus_power_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [6:0] DEV_ADDR = 7'h2a; // Arbitrary address for this run.
	localparam int         TIMEOUT  = 4000;

	logic       ref_clk_i, link_clk_i, sys_rst_i;
	logic       cmd_valid_i, cmd_ready_o, done_o, nack_o;
	host_kind_e cmd_kind_i;
	logic [6:0] cmd_addr_i;
	logic [7:0] cmd_reg_i, cmd_data_i, rd_data_o, cfg;
	logic       run_mode_o, meas_powered_o, set_done_o;
	logic [1:0] conv_channel_o;
	int         n_mismatch, tests_run, seed, s0;
	int         sets_seen = 0;

	smbus_link_if link();

	////////////////////////////////////////////////////////////////////////////////
	// Both ends, plus the checker beside the link.
	smbus_sensor_slave #(.SLAVE_ADDR(DEV_ADDR), .TIMEOUT_CYCLES(TIMEOUT),
		.SET_PERIOD_CYCLES(200), .CONV_CYCLES(10)) u_smbus_sensor_slave (
		.ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .sys_rst_i(sys_rst_i),
		.link(link), .run_mode_o(run_mode_o), .meas_powered_o(meas_powered_o),
		.conv_channel_o(conv_channel_o), .set_done_o(set_done_o));
	smbus_host_master u_smbus_host_master (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .link(link),
		.cmd_valid_i(cmd_valid_i), .cmd_kind_i(cmd_kind_i), .cmd_addr_i(cmd_addr_i),
		.cmd_reg_i(cmd_reg_i), .cmd_data_i(cmd_data_i), .cmd_ready_o(cmd_ready_o),
		.done_o(done_o), .nack_o(nack_o), .rd_data_o(rd_data_o));
	smbus_power_assertions #(.TIMEOUT_CYCLES(TIMEOUT)) u_smbus_power_assertions (
		.ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .sys_rst_i(sys_rst_i),
		.host_data_oe(link.host_data_oe), .dev_clock_oe(link.dev_clock_oe),
		.dev_data_oe(link.dev_data_oe), .serial_clock_pin(link.serial_clock_pin),
		.serial_data_pin(link.serial_data_pin), .run_mode_o(run_mode_o),
		.meas_powered_o(meas_powered_o), .set_done_o(set_done_o));

	////////////////////////////////////////////////////////////////////////////////
	// Clocks; the link clock runs free at an unrelated phase.
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#1.7;
		forever #3 link_clk_i = ~link_clk_i;
	end

	// Set-done pulses last one cycle, so the falling edge sees each exactly once.
	// Each set ends on the last channel.
	always @(negedge ref_clk_i) begin
		if (set_done_o === 1'b1) begin
			sets_seen++;
			chk({6'h00, conv_channel_o}, 8'(`NUM_CHANNELS - 1));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask

	task automatic print_verdict;
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// One host command; an idle host takes it at the next rising edge.
	task automatic xfer(input host_kind_e kind, input logic [6:0] addr,
		input logic [7:0] regc, input logic [7:0] data, input logic exp_nack);
		int i;
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b1;
		cmd_kind_i  = kind;
		cmd_addr_i  = addr;
		cmd_reg_i   = regc;
		cmd_data_i  = data;
		@(negedge ref_clk_i);
		cmd_valid_i = 1'b0;
		chk({7'h00, cmd_ready_o}, 8'h00);
		for (i = 0; i < 12000 && done_o !== 1'b1; i++) @(negedge ref_clk_i);
		if (i == 12000) begin
			n_mismatch++;
			print_verdict();
		end
		chk({7'h00, nack_o}, {7'h00, exp_nack});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		seed = 40422;
		{n_mismatch, tests_run} = '0;
		{cmd_valid_i, cmd_addr_i, cmd_reg_i, cmd_data_i} = '0;
		cmd_kind_i = K_WRITE_BYTE;
		sys_rst_i  = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
		chk({6'h00, run_mode_o, meas_powered_o}, 8'h00);
		cfg = 8'($random(seed)) & 8'hfe;
		xfer(K_WRITE_BYTE, DEV_ADDR, `REG_CONFIG, cfg, 1'b0);
		xfer(K_READ_BYTE, DEV_ADDR, `REG_CONFIG, 8'h00, 1'b0);
		chk(rd_data_o, cfg);
		// Pointing at the trigger register must not start a set.
		s0 = sets_seen;
		xfer(K_SEND_BYTE, DEV_ADDR, `REG_ONE_SHOT, 8'h00, 1'b0);
		xfer(K_RECEIVE_BYTE, DEV_ADDR, 8'h00, 8'h00, 1'b0);
		chk(rd_data_o, 8'h00);
		chk(8'(sets_seen - s0), 8'h00);
		xfer(K_SEND_BYTE, DEV_ADDR, `REG_CONFIG, 8'h00, 1'b0);
		repeat (2) begin
			xfer(K_RECEIVE_BYTE, DEV_ADDR, 8'h00, 8'h00, 1'b0);
			chk(rd_data_o, cfg);
		end
		// A foreign address is ignored and changes nothing.
		xfer(K_WRITE_BYTE, DEV_ADDR ^ (7'($random(seed)) | 7'h01), `REG_CONFIG, ~cfg, 1'b1);
		xfer(K_RECEIVE_BYTE, DEV_ADDR, 8'h00, 8'h00, 1'b0);
		chk(rd_data_o, cfg);
		s0 = sets_seen;
		xfer(K_WRITE_BYTE, DEV_ADDR, `REG_ONE_SHOT, 8'($random(seed)), 1'b0);
		repeat (400) @(negedge ref_clk_i);
		chk(8'(sets_seen - s0), 8'h01);
		chk({7'h00, run_mode_o}, 8'h00);
		s0 = sets_seen;
		xfer(K_WRITE_BYTE, DEV_ADDR, `REG_CONFIG, cfg | 8'h01, 1'b0);
		repeat (1000) @(negedge ref_clk_i);
		chk({6'h00, run_mode_o, sets_seen - s0 >= 4}, 8'h03);
		xfer(K_READ_BYTE, DEV_ADDR, `REG_STATUS, 8'h00, 1'b0);
		chk(rd_data_o, 8'h03);
		xfer(K_RECEIVE_BYTE, DEV_ADDR, 8'h00, 8'h00, 1'b0);
		chk(rd_data_o, 8'h03);
		// Back to standby: the running set ends, then no more sets.
		cfg = 8'($random(seed)) & 8'hfe;
		xfer(K_WRITE_BYTE, DEV_ADDR, `REG_CONFIG, cfg, 1'b0);
		repeat (300) @(negedge ref_clk_i);
		s0 = sets_seen;
		repeat (600) @(negedge ref_clk_i);
		chk({run_mode_o, 7'(sets_seen - s0)}, 8'h00);
		xfer(K_READ_BYTE, DEV_ADDR, `REG_CONFIG, 8'h00, 1'b0);
		chk(rd_data_o, cfg);
		print_verdict();
	end
endmodule // smbus_slave_power_mode_ctrl_bench

// File: verilog/smbus_host_master.sv
// Host end: bus master that issues the four byte protocols, clock made by a divider.
`include "smbus_power_map.svh"

module smbus_host_master
	import smbus_power_pkg::*;
(
	// Clock and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       sys_rst_i,
	// Bus pins.
	smbus_link_if.host      link,
	// Command request.
	input  wire logic       cmd_valid_i,
	input  wire host_kind_e cmd_kind_i,
	input  wire logic [6:0] cmd_addr_i,
	input  wire logic [7:0] cmd_reg_i,
	input  wire logic [7:0] cmd_data_i,
	output logic            cmd_ready_o,
	// Command answer.
	output logic            done_o,
	output logic            nack_o,
	output logic [7:0]      rd_data_o
);

	////////////////////////////////////////////////////////////////////////////
	// Line synchronisers.

	logic scl_s1, scl_s2, sda_s1, sda_s2;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			{scl_s1, scl_s2} <= 2'b11;
			{sda_s1, sda_s2} <= 2'b11;
		end else begin
			{scl_s1, scl_s2} <= {link.serial_clock_pin, scl_s1};
			{sda_s1, sda_s2} <= {link.serial_data_pin, sda_s1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step table and quarter-bit line pattern.

	host_state_e hstate, next_hstate;
	host_kind_e  kind, next_kind;
	logic [6:0]  addr, next_addr;
	logic [7:0]  regb, next_regb;
	logic [7:0]  wdata, next_wdata;
	logic [2:0]  step, next_step;
	logic [3:0]  bitn, next_bitn;
	logic [1:0]  qtr, next_qtr;
	logic [7:0]  div, next_div;
	logic [7:0]  rx, next_rx;
	logic        abort, next_abort;
	logic        scl_low, next_scl_low;
	logic        sda_low, next_sda_low;
	logic        next_done, next_nack;
	logic [7:0]  next_rd_data;
	host_op_e    op;
	logic [7:0]  cur_byte;
	logic [2:0]  bidx;

	// Sequence of each protocol; a refused byte forces the stop.
	always_comb begin
		op       = OP_STOP;
		cur_byte = 8'h00;
		unique case (kind)
			K_WRITE_BYTE: unique case (step)
				3'd0:    op = OP_START;
				3'd1:    begin op = OP_TX; cur_byte = {addr, 1'b0}; end
				3'd2:    begin op = OP_TX; cur_byte = regb; end
				3'd3:    begin op = OP_TX; cur_byte = wdata; end
				default: op = OP_STOP;
			endcase
			K_SEND_BYTE: unique case (step)
				3'd0:    op = OP_START;
				3'd1:    begin op = OP_TX; cur_byte = {addr, 1'b0}; end
				3'd2:    begin op = OP_TX; cur_byte = regb; end
				default: op = OP_STOP;
			endcase
			K_RECEIVE_BYTE: unique case (step)
				3'd0:    op = OP_START;
				3'd1:    begin op = OP_TX; cur_byte = {addr, 1'b1}; end
				3'd2:    op = OP_RX;
				default: op = OP_STOP;
			endcase
			K_READ_BYTE: unique case (step)
				3'd0:    op = OP_START;
				3'd1:    begin op = OP_TX; cur_byte = {addr, 1'b0}; end
				3'd2:    begin op = OP_TX; cur_byte = regb; end
				3'd3:    op = OP_RSTART;
				3'd4:    begin op = OP_TX; cur_byte = {addr, 1'b1}; end
				3'd5:    op = OP_RX;
				default: op = OP_STOP;
			endcase
		endcase
		if (abort) begin
			op = OP_STOP;
		end
	end

	assign bidx = 3'd7 - bitn[2:0];

	// Sequencer. The divider stalls while a released clock is still held low,
	// which is how clock stretching by any agent is honoured.
	always_comb begin
		next_hstate  = hstate;
		next_kind    = kind;
		next_addr    = addr;
		next_regb    = regb;
		next_wdata   = wdata;
		next_step    = step;
		next_bitn    = bitn;
		next_qtr     = qtr;
		next_div     = div;
		next_rx      = rx;
		next_abort   = abort;
		next_done    = 1'b0;
		next_nack    = nack_o;
		next_rd_data = rd_data_o;
		next_scl_low = 1'b0;
		next_sda_low = 1'b0;
		if (hstate == H_IDLE) begin
			if (cmd_valid_i) begin
				next_hstate = H_RUN;
				next_kind   = cmd_kind_i;
				next_addr   = cmd_addr_i;
				next_regb   = cmd_reg_i;
				next_wdata  = cmd_data_i;
				next_step   = 3'd0;
				next_bitn   = 4'h0;
				next_qtr    = 2'd0;
				next_div    = 8'h00;
				next_abort  = 1'b0;
			end
		end else begin
			unique case (op)
				OP_START: begin
					next_sda_low = (qtr != 2'd0);
					next_scl_low = (qtr == 2'd3);
				end
				OP_RSTART: begin
					next_scl_low = (qtr == 2'd0) || (qtr == 2'd3);
					next_sda_low = (qtr >= 2'd2);
				end
				OP_STOP: begin
					next_scl_low = (qtr == 2'd0);
					next_sda_low = (qtr <= 2'd1);
				end
				OP_TX, OP_RX: begin
					next_scl_low = (qtr <= 2'd1);
					next_sda_low = (op == OP_TX) && (bitn != 4'h8) && !cur_byte[bidx];
				end
			endcase
			if (!(!scl_low && !scl_s2)) begin
				next_div = div + 8'h01;
			end
			if (div == 8'(`QUARTER_CYCLES - 1)) begin
				next_div = 8'h00;
				next_qtr = qtr + 2'd1;
				if (qtr == 2'd3) begin
					if (op == OP_TX || op == OP_RX) begin
						next_bitn = bitn + 4'h1;
						if (bitn != 4'h8) begin
							next_rx = {rx[6:0], sda_s2};
						end else begin
							next_bitn = 4'h0;
							next_step = step + 3'd1;
							if (op == OP_TX && sda_s2) begin
								next_abort = 1'b1;
							end
						end
					end else if (op == OP_STOP) begin
						next_hstate  = H_IDLE;
						next_done    = 1'b1;
						next_nack    = abort;
						next_rd_data = rx;
					end else begin
						next_step = step + 3'd1;
					end
				end
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hstate    <= H_IDLE;
			kind      <= K_WRITE_BYTE;
			addr      <= 7'h00;
			regb      <= 8'h00;
			wdata     <= 8'h00;
			step      <= 3'd0;
			bitn      <= 4'h0;
			qtr       <= 2'd0;
			div       <= 8'h00;
			rx        <= 8'h00;
			abort     <= 1'b0;
			scl_low   <= 1'b0;
			sda_low   <= 1'b0;
			done_o    <= 1'b0;
			nack_o    <= 1'b0;
			rd_data_o <= 8'h00;
		end else begin
			hstate    <= next_hstate;
			kind      <= next_kind;
			addr      <= next_addr;
			regb      <= next_regb;
			wdata     <= next_wdata;
			step      <= next_step;
			bitn      <= next_bitn;
			qtr       <= next_qtr;
			div       <= next_div;
			rx        <= next_rx;
			abort     <= next_abort;
			scl_low   <= next_scl_low;
			sda_low   <= next_sda_low;
			done_o    <= next_done;
			nack_o    <= next_nack;
			rd_data_o <= next_rd_data;
		end
	end

	// Open-drain drive from flops.
	assign link.host_clock_out = 1'b0;
	assign link.host_clock_oe  = scl_low;
	assign link.host_data_out  = 1'b0;
	assign link.host_data_oe   = sda_low;
	assign cmd_ready_o         = (hstate == H_IDLE);

endmodule // smbus_host_master

// File: verilog/smbus_link_if.sv
// Two-wire open-drain link between the bus host and the sensor slave.
interface smbus_link_if;

	// Per-end drive of each open-drain line.
	logic host_clock_out;
	logic host_clock_oe;
	logic host_data_out;
	logic host_data_oe;
	logic dev_clock_out;
	logic dev_clock_oe;
	logic dev_data_out;
	logic dev_data_oe;

	// Resolved line levels; pull-ups make an undriven line high.
	logic serial_clock_pin;
	logic serial_data_pin;

	// Wired-AND of both ends.
	assign serial_clock_pin = ~((host_clock_oe & ~host_clock_out) |
		(dev_clock_oe & ~dev_clock_out));
	assign serial_data_pin  = ~((host_data_oe & ~host_data_out) |
		(dev_data_oe & ~dev_data_out));

	modport host (
		input  serial_clock_pin, serial_data_pin,
		output host_clock_out, host_clock_oe, host_data_out, host_data_oe
	);

	modport device (
		input  serial_clock_pin, serial_data_pin,
		output dev_clock_out, dev_clock_oe, dev_data_out, dev_data_oe
	);

endinterface

// File: verilog/smbus_power_map.svh
// Offsets, field positions, reset values and timing counts of the sensor bus block.
`ifndef SMBUS_POWER_MAP_SVH
`define SMBUS_POWER_MAP_SVH

// Register command codes reached through the register pointer.
`define REG_STATUS        8'h02
`define REG_CONFIG        8'h03
`define REG_ONE_SHOT      8'h0f

// Field positions and reset values.
`define CFG_RUN_BIT       0
`define STS_BUSY_BIT      0
`define STS_RUN_BIT       1
`define CONFIG_RESET      8'h00
`define POINTER_RESET     8'h00

// Measurement sequencing.
`define NUM_CHANNELS      3
`define DEFAULT_SETS_PER_S 1

// Clocks and bus timing.
`define REF_CLK_FREQ_KHZ  20000
`define LINK_CLK_PERIOD_NS 6
`define SCL_FREQ_KHZ      100
`define SMB_TIMEOUT_MS    25
`define QUARTER_CYCLES    (`REF_CLK_FREQ_KHZ / (`SCL_FREQ_KHZ * 4))
`define TIMEOUT_CYCLES    (`SMB_TIMEOUT_MS * 1000000 / `LINK_CLK_PERIOD_NS)
`define SET_PERIOD_CYCLES (`REF_CLK_FREQ_KHZ * 1000 / `DEFAULT_SETS_PER_S)

`endif

// File: verilog/smbus_power_pkg.sv
// Types shared by both ends of the sensor bus block.
package smbus_power_pkg;

	// Slave protocol engine states.
	typedef enum logic [3:0] {
		S_IDLE, S_ADDR, S_ACK_ADDR, S_CMD, S_ACK_CMD,
		S_DATA, S_ACK_DATA, S_TX, S_IGNORE
	} slave_state_e;

	// Measurement power sequencer states.
	typedef enum logic [1:0] {
		C_STANDBY, C_CONV, C_WAIT
	} conv_state_e;

	// Host transaction kinds.
	typedef enum logic [1:0] {
		K_WRITE_BYTE, K_READ_BYTE, K_SEND_BYTE, K_RECEIVE_BYTE
	} host_kind_e;

	// Host bus operations, four quarter bits each.
	typedef enum logic [2:0] {
		OP_START, OP_TX, OP_RX, OP_RSTART, OP_STOP
	} host_op_e;

	typedef enum logic {
		H_IDLE, H_RUN
	} host_state_e;

endpackage

// File: verilog/smbus_sensor_slave.sv
// Sensor end: bus slave on the link clock, power-mode sequencer on the reference clock.
`include "smbus_power_map.svh"

// Operation
// - Slave only, registers reachable over bus.
// - Write byte: address, command, data acknowledged.
// - Single-byte register read supported.
// - Send byte loads register pointer.
// - Send byte never writes register contents.
// - Receive byte returns register at pointer.
// - Receive byte leaves pointer unchanged.
// - Answer one fixed slave address.
// - Foreign address or protocol: silent, no change.
// - Never hold serial clock low.
// - Idle bus for 25 ms resets interface.
// - Run mode converts at rate, waits low-power.
// - Power-up in standby, monitoring off.
// - Bus stays fully operational in standby.
// - One-shot write in standby runs one set.
module smbus_sensor_slave
	import smbus_power_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR        = 7'h2a,  // Arbitrary value; set per variant.
	parameter int         TIMEOUT_CYCLES    = `TIMEOUT_CYCLES,
	parameter int         SET_PERIOD_CYCLES = `SET_PERIOD_CYCLES,
	parameter int         CONV_CYCLES       = 1000
) (
	// Clocks and reset.
	input  wire logic       ref_clk_i,
	input  wire logic       link_clk_i,
	input  wire logic       sys_rst_i,
	// Bus pins.
	smbus_link_if.device    link,
	// Measurement control.
	output logic            run_mode_o,
	output logic            meas_powered_o,
	output logic [1:0]      conv_channel_o,
	output logic            set_done_o
);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: reset release, pin synchronisers, edge detection.

	logic [1:0]   link_rst_ff;
	logic         link_rst;
	logic         scl_s1, scl_s2, scl_d;
	logic         sda_s1, sda_s2, sda_d;
	logic [1:0]   busy_sync;
	logic [1:0]   run_sync;
	logic         meas_busy, next_meas_busy;

	// Reset is asserted at once but released on the link clock.
	always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			link_rst_ff <= 2'b11;
		end else begin
			link_rst_ff <= {link_rst_ff[0], 1'b0};
		end
	end
	assign link_rst = link_rst_ff[1];

	// Pins and ref-domain status pass two flops; the delayed copy reads only stage two.
	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			{scl_s1, scl_s2, scl_d} <= 3'b111;
			{sda_s1, sda_s2, sda_d} <= 3'b111;
			busy_sync               <= 2'b00;
			run_sync                <= 2'b00;
		end else begin
			{scl_s1, scl_s2, scl_d} <= {link.serial_clock_pin, scl_s1, scl_s2};
			{sda_s1, sda_s2, sda_d} <= {link.serial_data_pin, sda_s1, sda_s2};
			busy_sync               <= {busy_sync[0], meas_busy};
			run_sync                <= {run_sync[0], run_mode_o};
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop, bus_moved;
	assign scl_rise  = scl_s2 & ~scl_d;
	assign scl_fall  = ~scl_s2 & scl_d;
	assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
	assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;
	assign bus_moved = (scl_s2 != scl_d) | (sda_s2 != sda_d);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: slave protocol engine and registers.

	slave_state_e state, next_state;
	logic [3:0]   bit_cnt, next_bit_cnt;
	logic [7:0]   rx_sh, next_rx_sh;
	logic [7:0]   tx_sh, next_tx_sh;
	logic         rd_dir, next_rd_dir;
	logic [7:0]   pointer, next_pointer;
	logic [7:0]   config_reg, next_config_reg;
	logic         shot_tgl, next_shot_tgl;
	logic         sda_oe, next_sda_oe;
	logic [22:0]  idle_cnt, next_idle_cnt;
	logic [7:0]   read_data;

	// Read mux; unmapped commands read as zero.
	always_comb begin
		read_data = 8'h00;
		unique case (pointer)
			`REG_STATUS: begin
				read_data[`STS_BUSY_BIT] = busy_sync[1];
				read_data[`STS_RUN_BIT]  = run_sync[1];
			end
			`REG_CONFIG: read_data = config_reg;
			default:     read_data = 8'h00;
		endcase
	end

	// Protocol decode. Start and stop win over bit handling so that any broken or
	// unsupported sequence is abandoned cleanly at the next framing condition.
	always_comb begin
		next_state      = state;
		next_bit_cnt    = bit_cnt;
		next_rx_sh      = rx_sh;
		next_tx_sh      = tx_sh;
		next_rd_dir     = rd_dir;
		next_pointer    = pointer;
		next_config_reg = config_reg;
		next_shot_tgl   = shot_tgl;
		next_sda_oe     = sda_oe;
		next_idle_cnt   = (state == S_IDLE || bus_moved) ? 23'h0 : idle_cnt + 23'h1;
		if (state != S_IDLE && idle_cnt == 23'(TIMEOUT_CYCLES - 1)) begin
			next_state    = S_IDLE;
			next_sda_oe   = 1'b0;
			next_idle_cnt = 23'h0;
		end else if (bus_start) begin
			next_state   = S_ADDR;
			next_bit_cnt = 4'h0;
			next_sda_oe  = 1'b0;
		end else if (bus_stop) begin
			next_state  = S_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			unique case (state)
				S_ADDR, S_CMD, S_DATA: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						next_rx_sh   = {rx_sh[6:0], sda_s2};
						next_bit_cnt = bit_cnt + 4'h1;
					end
					if (scl_fall && bit_cnt == 4'h8) begin
						next_bit_cnt = 4'h0;
						next_sda_oe  = 1'b1;
						if (state == S_ADDR) begin
							if (rx_sh[7:1] == SLAVE_ADDR) begin
								next_rd_dir = rx_sh[0];
								next_state  = S_ACK_ADDR;
							end else begin
								next_sda_oe = 1'b0;
								next_state  = S_IGNORE;
							end
						end else if (state == S_CMD) begin
							next_pointer = rx_sh;
							next_state   = S_ACK_CMD;
						end else begin
							// Only a data byte after a command writes.
							if (pointer == `REG_CONFIG) begin
								next_config_reg = rx_sh;
							end else if (pointer == `REG_ONE_SHOT) begin
								next_shot_tgl = ~shot_tgl;
							end
							next_state = S_ACK_DATA;
						end
					end
				end
				S_ACK_ADDR: begin
					if (scl_fall) begin
						if (rd_dir) begin
							// Pointer is read, not moved.
							next_tx_sh  = read_data;
							next_sda_oe = ~read_data[7];
							next_state  = S_TX;
						end else begin
							next_sda_oe = 1'b0;
							next_state  = S_CMD;
						end
					end
				end
				S_ACK_CMD: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_state  = S_DATA;
					end
				end
				S_ACK_DATA: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_state  = S_IGNORE;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						next_tx_sh   = {tx_sh[6:0], 1'b0};
						next_bit_cnt = bit_cnt + 4'h1;
					end
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							// Single byte only; the slave releases after the eighth bit and does not read the host's acknowledge.
							next_sda_oe = 1'b0;
							next_state  = S_IGNORE;
						end else begin
							next_sda_oe = ~tx_sh[7];
						end
					end
				end
				S_IDLE, S_IGNORE: begin
				end
			endcase
		end
	end

	// Register the slave state; the bus answers in every power mode.
	always_ff @(posedge link_clk_i or posedge link_rst) begin
		if (link_rst) begin
			state      <= S_IDLE;
			bit_cnt    <= 4'h0;
			rx_sh      <= 8'h00;
			tx_sh      <= 8'h00;
			rd_dir     <= 1'b0;
			pointer    <= `POINTER_RESET;
			config_reg <= `CONFIG_RESET;
			shot_tgl   <= 1'b0;
			sda_oe     <= 1'b0;
			idle_cnt   <= 23'h0;
		end else begin
			state      <= next_state;
			bit_cnt    <= next_bit_cnt;
			rx_sh      <= next_rx_sh;
			tx_sh      <= next_tx_sh;
			rd_dir     <= next_rd_dir;
			pointer    <= next_pointer;
			config_reg <= next_config_reg;
			shot_tgl   <= next_shot_tgl;
			sda_oe     <= next_sda_oe;
			idle_cnt   <= next_idle_cnt;
		end
	end

	// Data is pulled low only; the clock line is never driven.
	assign link.dev_data_out  = 1'b0;
	assign link.dev_data_oe   = sda_oe;
	assign link.dev_clock_out = 1'b0;
	assign link.dev_clock_oe  = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// Reference domain: run bit and one-shot toggle crossing, sequencer.

	logic [1:0]   cfg_run_sync;
	logic [2:0]   shot_sync;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_run_sync <= 2'b00;
			shot_sync    <= 3'b000;
		end else begin
			cfg_run_sync <= {cfg_run_sync[0], config_reg[`CFG_RUN_BIT]};
			shot_sync    <= {shot_sync[1:0], shot_tgl};
		end
	end

	conv_state_e  cstate, next_cstate;
	logic [1:0]   chan, next_chan;
	logic [15:0]  conv_cnt, next_conv_cnt;
	logic [24:0]  period_cnt, next_period_cnt;
	logic         single, next_single;
	logic         next_set_done;
	logic         shot_req;

	assign shot_req = shot_sync[2] ^ shot_sync[1];

	// A one-shot in run mode is ignored: the running sets already refresh data.
	always_comb begin
		next_cstate     = cstate;
		next_chan       = chan;
		next_conv_cnt   = conv_cnt;
		next_period_cnt = period_cnt + 25'h1;
		next_single     = single;
		next_set_done   = 1'b0;
		unique case (cstate)
			C_STANDBY: begin
				next_period_cnt = 25'h0;
				if (cfg_run_sync[1] || shot_req) begin
					next_single   = ~cfg_run_sync[1];
					next_cstate   = C_CONV;
					next_chan     = 2'h0;
					next_conv_cnt = 16'h0;
				end
			end
			C_CONV: begin
				next_conv_cnt = conv_cnt + 16'h1;
				if (conv_cnt == 16'(CONV_CYCLES - 1)) begin
					next_conv_cnt = 16'h0;
					if (chan == 2'(`NUM_CHANNELS - 1)) begin
						next_set_done = 1'b1;
						next_cstate   = (single || !cfg_run_sync[1]) ? C_STANDBY : C_WAIT;
						next_single   = 1'b0;
					end else begin
						next_chan = chan + 2'h1;
					end
				end
			end
			C_WAIT: begin
				if (!cfg_run_sync[1]) begin
					next_cstate = C_STANDBY;
				end else if (period_cnt >= 25'(SET_PERIOD_CYCLES - 1)) begin
					next_cstate     = C_CONV;
					next_chan       = 2'h0;
					next_period_cnt = 25'h0;
				end
			end
		endcase
		// Busy is registered so the link side never samples a decode glitch.
		next_meas_busy = (next_cstate != C_STANDBY);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cstate     <= C_STANDBY;
			meas_busy  <= 1'b0;
			chan       <= 2'h0;
			conv_cnt   <= 16'h0;
			period_cnt <= 25'h0;
			single     <= 1'b0;
			set_done_o <= 1'b0;
		end else begin
			cstate     <= next_cstate;
			chan       <= next_chan;
			conv_cnt   <= next_conv_cnt;
			period_cnt <= next_period_cnt;
			single     <= next_single;
			set_done_o <= next_set_done;
			meas_busy  <= next_meas_busy;
		end
	end

	// Converter power is on only while a channel converts.
	assign meas_powered_o = (cstate == C_CONV);
	assign conv_channel_o = chan;
	assign run_mode_o     = cfg_run_sync[1];

endmodule // smbus_sensor_slave
